// >>> src/stsc_cmd_core.sv
// Command interpreter for stall-terminate and sync commands
// Behaviour
// - Stall-terminate marks stalled transactions of stream
// - Outstanding stalled transactions end with abort
// - No stalled transactions means no change
// - Affected stall tags return to pool
// - No stall support raises illegal error
// - Marked transactions terminate later for sure
// - Later stalls are not affected
// - Isolated queue stall-terminate is illegal
// - Violated preconditions give undefined outcome
// - No stall records after synced termination
// - Full event queue: retry or mark
// - Sync covers prior commands and records
// - Effects visible before completion signal
// - Signal only after consumption is visible
// - No-signal sync ignores message parameters
// - Interrupt sync writes message if address
// - No message support ignores message fields
// - Wired interrupt pulses on interrupt sync only with wired support
// - Event wakeup only with event support
// - Later commands wait for sync completion
// - Message is one aligned word write
`timescale 1ns/1ps
module stsc_cmd_core (
   // Clock and reset
   input wire logic MCLK_IN,
   input wire logic RESET_IN,
   // Register port
   input wire logic [7:0] REG_ADDR_IN,
   input wire logic [31:0] REG_WDATA_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   output logic [31:0] REG_RDATA_OUT,
   // Command queue
   input wire logic CMD_VALID_IN,
   input stsc_pkg::stsc_cmd_t CMD_IN,
   output logic CMD_READY_OUT,
   // Stalled transactions arriving
   input wire logic STALL_VALID_IN,
   input stsc_pkg::stsc_stall_t STALL_IN,
   output logic STALL_READY_OUT,
   output logic [stsc_pkg::TAG_W-1:0] STALL_TAG_OUT,
   // Stream configuration is now terminating
   input wire logic STREAM_TERMINATING_IN,
   // Termination of marked transactions
   input wire logic TERM_READY_IN,
   output logic TERM_VALID_OUT,
   output logic [stsc_pkg::TAG_W-1:0] TERM_TAG_OUT,
   // Pending event record writes and table updates
   input wire logic SYS_IDLE_IN,
   // Message write
   output logic MSG_VALID_OUT,
   output stsc_pkg::stsc_msg_t MSG_OUT,
   input wire logic MSG_READY_IN,
   // Completion signals
   output logic WIRED_IRQ_OUT,
   output logic EVENT_WAKE_OUT
);

   // ==========================================================
   // State machine
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_DRAIN = 5'b00010,
      ST_CONSUME = 5'b00100,
      ST_SIGNAL = 5'b01000,
      ST_MSG = 5'b10000
   } stsc_state_t;

   stsc_state_t state_reg, state_next;
   stsc_pkg::stsc_cmd_t cmd_reg, cmd_next;
   logic [31:0] ctrl_reg, ctrl_next;
   logic [31:0] cons_reg, cons_next;
   logic [7:0] err_reg, err_next;
   logic [31:0] rdata_reg, rdata_next;
   logic ready_reg, ready_next;
   logic msg_valid_reg, msg_valid_next;
   stsc_pkg::stsc_msg_t msg_reg, msg_next;
   logic irq_reg, irq_next;
   logic wake_reg, wake_next;
   logic mark_pulse;
   logic err_set;
   stsc_pkg::stsc_stall_t mark_key;
   logic table_busy;
   logic stall_ok, stall_ready;
   logic [stsc_pkg::TAG_W-1:0] stall_tag;
   logic term_valid;
   logic [stsc_pkg::TAG_W-1:0] term_tag;

   // Legality check of a stall-terminate command
   function automatic logic stall_term_illegal(
      input logic [31:0] ctrl, input logic isolated);
      logic [1:0] model;
      model = ctrl[stsc_pkg::CTRL_STALL_MODEL_LSB +: 2];
      return isolated || (model == stsc_pkg::STALL_MODEL_NONE);
   endfunction : stall_term_illegal

   // ==========================================================
   // Stall table
   assign mark_key.stream_number = cmd_reg.stream_number;
   assign mark_key.security_select = cmd_reg.security_select;
   // New stalls refused once stream terminating
   assign stall_ok = STALL_VALID_IN && !STREAM_TERMINATING_IN;

   stsc_stall_table u_table (
      .clk_in(MCLK_IN),
      .rst_in(RESET_IN),
      .stall_valid_in(stall_ok),
      .stall_in(STALL_IN),
      .stall_ready_out(stall_ready),
      .stall_tag_out(stall_tag),
      .mark_in(mark_pulse),
      .mark_key_in(mark_key),
      .term_ready_in(TERM_READY_IN),
      .term_valid_out(term_valid),
      .term_tag_out(term_tag),
      .busy_out(table_busy)
   );

   // ==========================================================
   // Command sequencing
   always_comb begin
      state_next = state_reg;
      cmd_next = cmd_reg;
      cons_next = cons_reg;
      err_next = err_reg;
      ready_next = 1'b0;
      msg_valid_next = msg_valid_reg;
      msg_next = msg_reg;
      irq_next = 1'b0;
      wake_next = 1'b0;
      mark_pulse = 1'b0;
      err_set = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            // Take one command; next waits until this one done
            if (CMD_VALID_IN && !ready_reg) begin
               cmd_next = CMD_IN;
               ready_next = 1'b1;
               if (CMD_IN.opcode == stsc_pkg::OP_STALL_TERM) begin
                  if (stall_term_illegal(ctrl_reg,
                      CMD_IN.isolated_queue)) begin
                     err_next = stsc_pkg::ERR_ILLEGAL;
                     err_set = 1'b1;
                  end else begin
                     state_next = ST_CONSUME;
                  end
                  cons_next = cons_reg + 32'h1;
               end else if (CMD_IN.opcode == stsc_pkg::OP_SYNC) begin
                  state_next = ST_DRAIN;
               end else begin
                  cons_next = cons_reg + 32'h1;
               end
            end
         end
         ST_CONSUME: begin
            // Mark matching stalls; none matching changes nothing
            mark_pulse = 1'b1;
            state_next = ST_IDLE;
         end
         ST_DRAIN: begin
            // Wait until prior work and records are visible
            if (SYS_IDLE_IN) begin
               cons_next = cons_reg + 32'h1;
               state_next = ST_SIGNAL;
            end
         end
         ST_SIGNAL: begin
            // Consume index already advanced before signalling
            state_next = ST_IDLE;
            case (cmd_reg.completion_signal_field)
               stsc_pkg::SIGNAL_INTERRUPT_C: begin
                  irq_next = ctrl_reg[stsc_pkg::CTRL_WIRED_SUP_BIT];
                  if (ctrl_reg[stsc_pkg::CTRL_MSG_SUP_BIT] &&
                      |cmd_reg.message_target_address) begin
                     msg_valid_next = 1'b1;
                     msg_next.addr = {cmd_reg.message_target_address,
                                      2'b00};
                     msg_next.data = cmd_reg.message_payload;
                     msg_next.attr = cmd_reg.message_write_attr;
                     state_next = ST_MSG;
                  end
               end
               stsc_pkg::SIG_EVENT_C: begin
                  wake_next = ctrl_reg[stsc_pkg::CTRL_EVENT_SUP_BIT];
               end
               stsc_pkg::SIGNAL_NONE_C: begin
                  state_next = ST_IDLE;
               end
               default: begin
                  err_next = stsc_pkg::ERR_ILLEGAL;
                  err_set = 1'b1;
               end
            endcase
         end
         ST_MSG: begin
            // Hold the word write until accepted
            if (MSG_READY_IN) begin
               msg_valid_next = 1'b0;
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      if (REG_WR_IN && REG_ADDR_IN == stsc_pkg::REG_ERROR) begin
         if (!err_set) begin // Hardware set wins
            err_next = stsc_pkg::ERR_NONE;
         end
      end
   end

   // Sequencer registers
   always_ff @(posedge MCLK_IN) begin
      if (RESET_IN) begin
         state_reg <= ST_IDLE;
         cmd_reg <= '0;
         cons_reg <= '0;
         err_reg <= stsc_pkg::ERR_NONE;
         ready_reg <= 1'b0;
         msg_valid_reg <= 1'b0;
         msg_reg <= '0;
         irq_reg <= 1'b0;
         wake_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cmd_reg <= cmd_next;
         cons_reg <= cons_next;
         err_reg <= err_next;
         ready_reg <= ready_next;
         msg_valid_reg <= msg_valid_next;
         msg_reg <= msg_next;
         irq_reg <= irq_next;
         wake_reg <= wake_next;
      end
   end

   // ==========================================================
   // Register port
   always_comb begin
      ctrl_next = ctrl_reg;
      rdata_next = 32'h0;
      if (REG_WR_IN) begin
         if (REG_ADDR_IN == stsc_pkg::REG_CTRL) begin
            ctrl_next = {27'h0, REG_WDATA_IN[4:0]};
         end
      end
      if (REG_RD_IN) begin
         if (REG_ADDR_IN == stsc_pkg::REG_CTRL) begin
            rdata_next = ctrl_reg;
         end else if (REG_ADDR_IN == stsc_pkg::REG_STATUS) begin
            rdata_next = {24'h0, 2'h0, table_busy, state_reg};
         end else if (REG_ADDR_IN == stsc_pkg::REG_CONS) begin
            rdata_next = cons_reg;
         end else if (REG_ADDR_IN == stsc_pkg::REG_ERROR) begin
            rdata_next = {24'h0, err_reg};
         end else begin
            rdata_next = 32'h0;
         end
      end
   end

   // Register file
   always_ff @(posedge MCLK_IN) begin
      if (RESET_IN) begin
         ctrl_reg <= stsc_pkg::CTRL_RESET;
         rdata_reg <= 32'h0;
      end else begin
         ctrl_reg <= ctrl_next;
         rdata_reg <= rdata_next;
      end
   end

   // ==========================================================
   // Outputs
   logic stall_ready_reg;
   logic [stsc_pkg::TAG_W-1:0] stall_tag_reg;

   // Report of a captured stall and the tag it got
   always_ff @(posedge MCLK_IN) begin
      if (RESET_IN) begin
         stall_ready_reg <= 1'b0;
         stall_tag_reg <= '0;
      end else begin
         stall_ready_reg <= stall_ok && stall_ready;
         stall_tag_reg <= stall_tag;
      end
   end

   assign REG_RDATA_OUT = rdata_reg;
   assign CMD_READY_OUT = ready_reg;
   assign STALL_READY_OUT = stall_ready_reg;
   assign STALL_TAG_OUT = stall_tag_reg;
   assign TERM_VALID_OUT = term_valid;
   assign TERM_TAG_OUT = term_tag;
   assign MSG_VALID_OUT = msg_valid_reg;
   assign MSG_OUT = msg_reg;
   assign WIRED_IRQ_OUT = irq_reg;
   assign EVENT_WAKE_OUT = wake_reg;

endmodule : stsc_cmd_core

// >>> src/stsc_pkg.sv
// Package for the stall-terminate and sync command interpreter
package stsc_pkg;

   // ==========================================================
   // Command encodings
   localparam logic [7:0] OP_STALL_TERM = 8'h45;
   localparam logic [7:0] OP_SYNC = 8'h46;

   // ==========================================================
   // Completion signal field and stall model encodings
   localparam logic [1:0] SIGNAL_NONE_C = 2'h0;
   localparam logic [1:0] SIGNAL_INTERRUPT_C = 2'h1;
   localparam logic [1:0] SIG_EVENT_C = 2'h2;
   localparam logic [1:0] STALL_MODEL_NONE = 2'h1;

   // ==========================================================
   // Error codes reported for a refused command
   localparam logic [7:0] ERR_NONE = 8'h00;
   localparam logic [7:0] ERR_ILLEGAL = 8'h01;

   // ==========================================================
   // Register offsets (byte addresses, one word apart)
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_CONS = 8'h08;
   localparam logic [7:0] REG_ERROR = 8'h0c;

   // ==========================================================
   // Control register fields and reset value
   localparam int CTRL_STALL_MODEL_LSB = 0;
   localparam int CTRL_EVENT_SUP_BIT = 2;
   localparam int CTRL_MSG_SUP_BIT = 3;
   localparam int CTRL_WIRED_SUP_BIT = 4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_001c;

   // ==========================================================
   // Stall tracking sizes
   localparam int STALL_SLOTS = 8;
   localparam int SID_W = 16;
   localparam int TAG_W = 3;

   // ==========================================================
   // Timing: length of the wired interrupt and event pulses
   localparam int PULSE_NS = 10;
   localparam int CLK_NS = 10;
   localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;

   // ==========================================================
   // Command as taken from the queue
   typedef struct packed {
      logic [7:0] opcode;
      logic security_select;
      logic isolated_queue;
      logic [SID_W-1:0] stream_number;
      logic [1:0] completion_signal_field;
      logic [53:0] message_target_address;
      logic [31:0] message_payload;
      logic [3:0] message_write_attr;
   } stsc_cmd_t;

   // Outgoing message write
   typedef struct packed {
      logic [55:0] addr;
      logic [31:0] data;
      logic [3:0] attr;
   } stsc_msg_t;

   // Stall record entering the tracker
   typedef struct packed {
      logic [SID_W-1:0] stream_number;
      logic security_select;
   } stsc_stall_t;

endpackage : stsc_pkg

// >>> src/stsc_stall_table.sv
// Stall table holding stalled transactions and their tags
`timescale 1ns/1ps
module stsc_stall_table (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // New stall arriving
   input wire logic stall_valid_in,
   input stsc_pkg::stsc_stall_t stall_in,
   output logic stall_ready_out,
   output logic [stsc_pkg::TAG_W-1:0] stall_tag_out,
   // Bulk mark request
   input wire logic mark_in,
   input stsc_pkg::stsc_stall_t mark_key_in,
   // Termination drain
   input wire logic term_ready_in,
   output logic term_valid_out,
   output logic [stsc_pkg::TAG_W-1:0] term_tag_out,
   output logic busy_out
);

   localparam int N = stsc_pkg::STALL_SLOTS;

   logic [N-1:0] used_reg, used_next;
   logic [N-1:0] marked_reg, marked_next;
   stsc_pkg::stsc_stall_t key_reg [N];
   stsc_pkg::stsc_stall_t key_next [N];
   logic [stsc_pkg::TAG_W-1:0] free_idx, term_idx;
   logic free_any, term_any;
   logic pres_valid_reg, pres_valid_next;
   logic [stsc_pkg::TAG_W-1:0] pres_tag_reg, pres_tag_next;

   // Find first set bit of a slot vector
   function automatic logic [stsc_pkg::TAG_W-1:0] first_set(
      input logic [N-1:0] v);
      logic [stsc_pkg::TAG_W-1:0] r;
      r = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = stsc_pkg::TAG_W'(i);
         end
      end
      return r;
   endfunction : first_set

   // Slot selection
   always_comb begin
      free_any = ~&used_reg;
      free_idx = first_set(~used_reg);
      term_any = |marked_reg;
      term_idx = first_set(marked_reg);
   end

   // Next slot state: mark, drain and allocate
   always_comb begin
      used_next = used_reg;
      marked_next = marked_reg;
      key_next = key_reg;
      pres_valid_next = pres_valid_reg;
      pres_tag_next = pres_tag_reg;
      if (mark_in) begin
         for (int i = 0; i < N; i++) begin
            // Only stalls present now; later stalls untouched
            if (used_reg[i] && key_reg[i] == mark_key_in) begin
               marked_next[i] = 1'b1;
            end
         end
      end
      // Present one marked tag, hold it until taken, then free it
      if (pres_valid_reg && term_ready_in) begin
         used_next[pres_tag_reg] = 1'b0;
         marked_next[pres_tag_reg] = 1'b0;
         pres_valid_next = 1'b0;
      end else if (!pres_valid_reg && term_any) begin
         pres_valid_next = 1'b1;
         pres_tag_next = term_idx;
      end
      if (stall_valid_in && free_any) begin
         used_next[free_idx] = 1'b1;
         marked_next[free_idx] = 1'b0;
         key_next[free_idx] = stall_in;
      end
   end

   // Slot registers
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         used_reg <= '0;
         marked_reg <= '0;
         pres_valid_reg <= 1'b0;
         pres_tag_reg <= '0;
         for (int i = 0; i < N; i++) begin
            key_reg[i] <= '0;
         end
      end else begin
         used_reg <= used_next;
         marked_reg <= marked_next;
         pres_valid_reg <= pres_valid_next;
         pres_tag_reg <= pres_tag_next;
         key_reg <= key_next;
      end
   end

   // Outputs
   always_comb begin
      stall_ready_out = free_any;
      stall_tag_out = free_idx;
      term_valid_out = pres_valid_reg;
      term_tag_out = pres_tag_reg;
      busy_out = term_any;
   end

endmodule : stsc_stall_table

// >>> verification/stsc_cmd_core_assertions.sv
// Assertion checker for the command interpreter top ports
`timescale 1ns/1ps
module stsc_cmd_core_assertions (
   // Clock and reset
   input wire logic MCLK_IN,
   input wire logic RESET_IN,
   // Inputs from the environment
   input wire logic CMD_VALID_IN,
   input wire logic STALL_VALID_IN,
   input wire logic STREAM_TERMINATING_IN,
   input wire logic TERM_READY_IN,
   input wire logic MSG_READY_IN,
   // Outputs of the design
   input wire logic CMD_READY_OUT,
   input wire logic STALL_READY_OUT,
   input wire logic TERM_VALID_OUT,
   input wire logic [stsc_pkg::TAG_W-1:0] TERM_TAG_OUT,
   input wire logic MSG_VALID_OUT,
   input stsc_pkg::stsc_msg_t MSG_OUT,
   input wire logic WIRED_IRQ_OUT,
   input wire logic EVENT_WAKE_OUT
);
   // ==========================================================
   // Common clock and reset
   default clocking cb @(posedge MCLK_IN);
   endclocking
   default disable iff (RESET_IN);

   // Handshakes held off by the far side
   sequence msg_waiting;
      MSG_VALID_OUT && !MSG_READY_IN;
   endsequence
   sequence term_waiting;
      TERM_VALID_OUT && !TERM_READY_IN;
   endsequence

   // ==========================================================
   // Properties
   ready_once_a: assert property (
      CMD_READY_OUT |-> $past(CMD_VALID_IN) && !$past(CMD_READY_OUT))
      else $error("command ready without a waiting command");
   stall_refused_a: assert property (
      STALL_READY_OUT |-> $past(STALL_VALID_IN)
         && !$past(STREAM_TERMINATING_IN))
      else $error("stall accepted while stream terminating");
   msg_held_a: assert property (
      msg_waiting |=> MSG_VALID_OUT && $stable(MSG_OUT))
      else $error("message write dropped before accept");
   msg_aligned_a: assert property (
      MSG_VALID_OUT |-> MSG_OUT.addr[1:0] == 2'h0)
      else $error("message write not word aligned");
   msg_nonzero_a: assert property (
      MSG_VALID_OUT |-> MSG_OUT.addr != 56'h0)
      else $error("message write to address zero");
   irq_pulse_a: assert property (
      WIRED_IRQ_OUT |=> !WIRED_IRQ_OUT)
      else $error("wired interrupt longer than one cycle");
   event_pulse_a: assert property (
      EVENT_WAKE_OUT |=> !EVENT_WAKE_OUT)
      else $error("event wakeup longer than one cycle");
   term_held_a: assert property (
      term_waiting |=> TERM_VALID_OUT && $stable(TERM_TAG_OUT))
      else $error("termination dropped before accept");
endmodule : stsc_cmd_core_assertions

// >>> verification/stsc_cmd_core_test.sv
// Self-checking testbench for the stall-terminate and sync interpreter
`timescale 1ns/1ps
module stsc_cmd_core_test;
   // ==========================================================
   // Port signals and bench counters
   logic mclk, rst, reg_wr, reg_rd, cmd_valid, cmd_ready, stall_valid;
   logic stall_ready, stream_term, term_ready, term_valid, sys_idle;
   logic msg_valid, msg_ready, wired_irq, event_wake;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [stsc_pkg::TAG_W-1:0] stall_tag, term_tag, last_tag;
   logic [7:0] exp_mask = 8'h0;
   logic [7:0] term_mask = 8'h0;
   stsc_pkg::stsc_cmd_t cmd;
   stsc_pkg::stsc_stall_t stall;
   stsc_pkg::stsc_msg_t msg, last_msg;
   int n_errors, n_checks, n_irq, n_msg, n_evt, n_term, n_stall, n_take, i;

   // Design under test
   stsc_cmd_core stsc_cmd_core_inst (
      .MCLK_IN(mclk), .RESET_IN(rst), .REG_ADDR_IN(reg_addr),
      .REG_WDATA_IN(reg_wdata), .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd),
      .REG_RDATA_OUT(reg_rdata), .CMD_VALID_IN(cmd_valid), .CMD_IN(cmd),
      .CMD_READY_OUT(cmd_ready), .STALL_VALID_IN(stall_valid),
      .STALL_IN(stall), .STALL_READY_OUT(stall_ready),
      .STALL_TAG_OUT(stall_tag), .STREAM_TERMINATING_IN(stream_term),
      .TERM_READY_IN(term_ready), .TERM_VALID_OUT(term_valid),
      .TERM_TAG_OUT(term_tag), .SYS_IDLE_IN(sys_idle),
      .MSG_VALID_OUT(msg_valid), .MSG_OUT(msg), .MSG_READY_IN(msg_ready),
      .WIRED_IRQ_OUT(wired_irq), .EVENT_WAKE_OUT(event_wake)
   );

   // Clock of 10 ns
   always #5 mclk = ~mclk;

   // Count completion signals, terminations, stalls and taken commands
   always @(posedge mclk) begin
      if (wired_irq === 1'b1)
         n_irq++;
      if (event_wake === 1'b1)
         n_evt++;
      if (msg_valid === 1'b1 && msg_ready === 1'b1) begin
         n_msg++;
         last_msg = msg;
      end
      if (term_valid === 1'b1 && term_ready === 1'b1) begin
         n_term++;
         term_mask[term_tag] = 1'b1;
      end
      if (stall_ready === 1'b1) begin
         n_stall++;
         last_tag = stall_tag;
      end
      if (cmd_ready === 1'b1)
         n_take++;
   end

   // ==========================================================
   // Checking and closing
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask : check

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop

   // ==========================================================
   // Register port, command and stall drivers
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : reg_write

   task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      check(reg_rdata, exp);
   endtask : reg_check

   function automatic stsc_pkg::stsc_cmd_t mk(input logic [7:0] op,
         input logic [stsc_pkg::SID_W-1:0] sid, input logic sec,
         input logic iso, input logic [1:0] cs, input logic [53:0] a);
      stsc_pkg::stsc_cmd_t c;
      c = '0;
      c.opcode = op;
      c.stream_number = sid;
      c.security_select = sec;
      c.isolated_queue = iso;
      c.completion_signal_field = cs;
      c.message_target_address = a;
      c.message_payload = 32'h1234_abcd;
      c.message_write_attr = 4'h3;
      return c;
   endfunction : mk

   // Hold the command until ready shows, bounded
   task automatic do_cmd(input stsc_pkg::stsc_cmd_t c);
      int k;
      @(posedge mclk);
      cmd_valid <= 1'b1;
      cmd <= c;
      for (k = 0; k < 300; k++) begin
         @(posedge mclk);
         if (cmd_ready === 1'b1)
            break;
      end
      cmd_valid <= 1'b0;
      if (k == 300) begin
         n_errors++;
         $display("unexpected at %0t: command never taken", $time);
         report_and_stop();
      end
   endtask : do_cmd

   task automatic stall_term(input logic [15:0] sid, input logic sec,
         input logic iso);
      do_cmd(mk(stsc_pkg::OP_STALL_TERM, sid, sec, iso, 2'h0, 54'h0));
      repeat (12) @(posedge mclk);
   endtask : stall_term

   task automatic send_stall(input logic [15:0] sid, input logic sec);
      @(posedge mclk);
      stall_valid <= 1'b1;
      stall <= {sid, sec};
      @(posedge mclk);
      stall_valid <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask : send_stall

   // One sync under a given support setting; message accept is stalled
   task automatic sync_case(input logic [31:0] ctl, input logic [1:0] cs,
         input logic [53:0] a, input int ei, input int em, input int ee);
      reg_write(stsc_pkg::REG_CTRL, ctl);
      n_irq = 0;
      n_msg = 0;
      n_evt = 0;
      msg_ready <= 1'b0;
      do_cmd(mk(stsc_pkg::OP_SYNC, 16'h0, 1'b0, 1'b0, cs, a));
      repeat (6) @(posedge mclk);
      msg_ready <= 1'b1;
      repeat (6) @(posedge mclk);
      check(n_irq, ei);
      check(n_msg, em);
      check(n_evt, ee);
      if (em == 1) begin
         check(last_msg.addr, {a, 2'h0});
         check(last_msg.data, 32'h1234_abcd);
      end
   endtask : sync_case

   // ==========================================================
   // Main sequence
   initial begin
      mclk = 1'b0;
      rst = 1'b1;
      {reg_wr, reg_rd, cmd_valid, stall_valid, stream_term} = 5'h0;
      {term_ready, sys_idle, msg_ready} = 3'h7;
      reg_addr = 8'h0;
      reg_wdata = 32'h0;
      cmd = '0;
      stall = '0;
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      reg_check(stsc_pkg::REG_CTRL, stsc_pkg::CTRL_RESET);
      reg_check(stsc_pkg::REG_CONS, 32'h0);
      reg_check(8'h10, 32'h0);
      $display("test reset values done");
      // Two stalls to mark, one in the other security state, one elsewhere
      send_stall(16'h5, 1'b0);
      exp_mask[last_tag] = 1'b1;
      send_stall(16'h5, 1'b0);
      exp_mask[last_tag] = 1'b1;
      send_stall(16'h5, 1'b1);
      send_stall(16'h6, 1'b0);
      check(n_stall, 4);
      stream_term <= 1'b1;
      send_stall(16'h8, 1'b0);
      check(n_stall, 4);
      term_ready <= 1'b0;
      stall_term(16'h5, 1'b0, 1'b0);
      term_ready <= 1'b1;
      repeat (20) @(posedge mclk);
      check(term_mask, exp_mask);
      check(n_term, 2);
      stream_term <= 1'b0;
      send_stall(16'h5, 1'b0);
      stall_term(16'h9, 1'b0, 1'b0);
      check(n_term, 2);
      for (i = 0; i < 6; i++)
         send_stall(16'h7, 1'b0);
      check(n_stall, 10);
      reg_check(stsc_pkg::REG_CONS, 32'h2);
      $display("test stall terminate done");
      // Every completion mode against the support bits
      sync_case(32'h1c, 2'h0, 54'h40, 0, 0, 0);
      sync_case(32'h1c, 2'h1, 54'h40, 1, 1, 0);
      sync_case(32'h1c, 2'h1, 54'h0, 1, 0, 0);
      sync_case(32'h1c, 2'h2, 54'h40, 0, 0, 1);
      sync_case(32'h18, 2'h2, 54'h40, 0, 0, 0);
      sync_case(32'h14, 2'h1, 54'h41, 1, 0, 0);
      sync_case(32'h0c, 2'h1, 54'h41, 0, 1, 0);
      reg_check(stsc_pkg::REG_CONS, 32'h9);
      $display("test sync signals done");
      // Sync waits for idle; the next command waits for the sync
      reg_write(stsc_pkg::REG_CTRL, stsc_pkg::CTRL_RESET);
      sys_idle <= 1'b0;
      n_irq = 0;
      do_cmd(mk(stsc_pkg::OP_SYNC, 16'h0, 1'b0, 1'b0, 2'h1, 54'h40));
      @(negedge mclk); // Let the take counter settle
      i = n_take;
      fork
         stall_term(16'h9, 1'b0, 1'b0);
         begin
            reg_check(stsc_pkg::REG_CONS, 32'h9);
            repeat (8) @(posedge mclk);
            check(n_take, i);
            check(n_irq, 0);
            sys_idle <= 1'b1;
         end
      join
      check(n_irq, 1);
      reg_check(stsc_pkg::REG_CONS, 32'hb);
      $display("test sync ordering done");
      // Refused stall-terminate commands raise the error, mark nothing
      reg_write(stsc_pkg::REG_CTRL, 32'h1d);
      stall_term(16'h5, 1'b1, 1'b0);
      reg_check(stsc_pkg::REG_ERROR, {24'h0, stsc_pkg::ERR_ILLEGAL});
      reg_write(stsc_pkg::REG_ERROR, 32'h0);
      reg_write(stsc_pkg::REG_CTRL, stsc_pkg::CTRL_RESET);
      stall_term(16'h5, 1'b1, 1'b1);
      reg_check(stsc_pkg::REG_ERROR, {24'h0, stsc_pkg::ERR_ILLEGAL});
      check(n_term, 2);
      $display("test illegal commands done");
      report_and_stop();
   end
endmodule : stsc_cmd_core_test

// Attach the checker to the interpreter
bind stsc_cmd_core stsc_cmd_core_assertions stsc_cmd_core_assertions_inst (
   .MCLK_IN(MCLK_IN), .RESET_IN(RESET_IN), .CMD_VALID_IN(CMD_VALID_IN),
   .STALL_VALID_IN(STALL_VALID_IN),
   .STREAM_TERMINATING_IN(STREAM_TERMINATING_IN),
   .TERM_READY_IN(TERM_READY_IN), .MSG_READY_IN(MSG_READY_IN),
   .CMD_READY_OUT(CMD_READY_OUT), .STALL_READY_OUT(STALL_READY_OUT),
   .TERM_VALID_OUT(TERM_VALID_OUT), .TERM_TAG_OUT(TERM_TAG_OUT),
   .MSG_VALID_OUT(MSG_VALID_OUT), .MSG_OUT(MSG_OUT),
   .WIRED_IRQ_OUT(WIRED_IRQ_OUT), .EVENT_WAKE_OUT(EVENT_WAKE_OUT)
);
